// ===== pkg/lsb_pkg.sv
// constants and types shared by the logic, shift and branch execution unit
package lsb_pkg;

	// ----------------------------------------
	// operation codes from the decoder
	// ----------------------------------------
	typedef enum logic [4:0] {
		OP_NOP, OP_AND, OP_OR, OP_XOR, OP_NOT, OP_TEST,
		OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_RIGHT_THRU_CARRY, OP_ROT, OP_SHA, OP_SHL, OP_SHA32, OP_SHL32,
		OP_ADD_BNZ, OP_SUB_BNZ, OP_JCOND, OP_JMP, OP_CALL_SPECIAL
	} op_type;

	// ----------------------------------------
	// branch conditions
	// ----------------------------------------
	typedef enum logic [3:0] {
		COND_GEU_C, COND_LTU_NC, COND_EQ_Z, COND_NE_NZ, COND_GTU, COND_LEU,
		COND_PZ, COND_N, COND_GE, COND_LT, COND_LE, COND_GT, COND_O, COND_NO
	} cond_type;

	// ----------------------------------------
	// flag bit positions in the flag vector
	// ----------------------------------------
	localparam int FLAG_C_POS = 0;
	localparam int FLAG_Z_POS = 1;
	localparam int FLAG_S_POS = 2;
	localparam int FLAG_O_POS = 3;

	// ----------------------------------------
	// immediate count limits, widths and fixed addresses
	// ----------------------------------------
	localparam logic signed [4:0] IMM_COUNT_MIN = -5'sd8;
	localparam logic signed [4:0] IMM_COUNT_MAX = 5'sd8;
	localparam int                WORD_W        = 16;
	localparam int                PC_W          = 20;
	localparam logic [PC_W-1:0]   PC_RESET      = 20'h00000;
	localparam logic [PC_W-1:0]   SPECIAL_PAGE  = 20'hf0000;

endpackage : lsb_pkg

// ===== core/logic_shift_branch_unit.sv
// logic, rotate/shift and jump execution datapath for a 16-bit core
//
// The implementer's own choice: the placing of the registers.
`timescale 1ns/1ps

// Behaviour
// RULE1 - rotate left through carry: carry into bit 0, msb into carry
// RULE2 - rotate right through carry: carry into msb, bit 0 into carry
// RULE3 - multi-bit rotate by source count, byte or word width
// RULE4 - arithmetic shift: sign fill right, zero fill left, count from source
// RULE5 - logical shift: zero fill both directions, count from source
// RULE6 - immediate count within -8..+8; zero count is invalid
// RULE7 - 32-bit shifts use low pair or high pair register
// RULE8 - add-and-branch writes sum, branches when sum nonzero
// RULE9 - subtract-and-branch writes difference, branches when nonzero
// RULE10 - carry set branch on C=1, carry clear on C=0
// RULE11 - equal branch on Z=1, not-equal on Z=0
// RULE12 - positive-or-zero on S=0, negative on S=1
// RULE13 - signed less-than on S^O=1, greater-or-equal on 0
// RULE14 - overflow branch on O=1, no-overflow on O=0
// RULE15 - unsigned higher on C & ~Z, lower-or-same otherwise
// RULE16 - unconditional jump always loads the target
// RULE17 - special page call saves return address, jumps via vector
// RULE18 - signed less-or-equal on (S^O)|Z=1, greater-than on 0
// RULE19 - AND, OR, XOR, NOT byte or word; test writes nothing
// RULE20 - logic ops update S,Z; shifts S,Z,C; arithmetic shift also O
// RULE21 - register count is signed high byte of second data register
module logic_shift_branch_unit
	import lsb_pkg::*;
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	// decoded instruction
	input  wire logic             start_i,
	input  op_type                op_i,
	input  cond_type              cond_i,
	input  wire logic             word_i,
	input  wire logic             count_imm_i,
	input  wire logic signed [4:0] imm_count_i,
	input  wire logic             pair_high_i,
	// operands from register file and flags
	input  wire logic [15:0]      src_i,
	input  wire logic [15:0]      dst_i,
	input  wire logic [15:0]      count_reg_i,
	input  wire logic [31:0]      low_pair_i,
	input  wire logic [31:0]      high_pair_i,
	input  wire logic [3:0]       flags_i,
	input  wire logic [PC_W-1:0]  next_pc_i,
	input  wire logic [PC_W-1:0]  target_i,
	input  wire logic [PC_W-1:0]  special_vector_i,
	// results
	output logic                  done_o,
	output logic                  invalid_o,
	output logic [31:0]           result_o,
	output logic                  write_dst_o,
	output logic                  write_pair_o,
	output logic                  pair_high_o,
	output logic [3:0]            flags_o,
	output logic [3:0]            flags_we_o,
	output logic                  pc_load_o,
	output logic [PC_W-1:0]       pc_o,
	output logic                  push_ret_o,
	output logic [PC_W-1:0]       ret_addr_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic            done;
		logic            invalid;
		logic [31:0]     result;
		logic            write_dst;
		logic            write_pair;
		logic            pair_high;
		logic [3:0]      flags;
		logic [3:0]      flags_we;
		logic            pc_load;
		logic [PC_W-1:0] pc;
		logic            push_ret;
		logic [PC_W-1:0] ret_addr;
	} state_type;

	state_type s_q;
	state_type s_d;

	logic c_in;
	logic z_in;
	logic s_in;
	logic o_in;
	assign c_in = flags_i[FLAG_C_POS];
	assign z_in = flags_i[FLAG_Z_POS];
	assign s_in = flags_i[FLAG_S_POS];
	assign o_in = flags_i[FLAG_O_POS];

	// ----------------------------------------
	// condition evaluation
	// ----------------------------------------
	function automatic logic cond_true(input cond_type c, input logic cf, input logic zf,
		input logic sf, input logic of);
		logic t;
		t = 1'b0;
		case (c)
			COND_GEU_C:  t = cf;                  // RULE10
			COND_LTU_NC: t = ~cf;                 // RULE10
			COND_EQ_Z:   t = zf;                  // RULE11
			COND_NE_NZ:  t = ~zf;                 // RULE11
			COND_GTU:    t = cf & ~zf;            // RULE15
			COND_LEU:    t = ~(cf & ~zf);         // RULE15
			COND_PZ:     t = ~sf;                 // RULE12
			COND_N:      t = sf;                  // RULE12
			COND_LT:     t = sf ^ of;             // RULE13
			COND_GE:     t = ~(sf ^ of);          // RULE13
			COND_LE:     t = (sf ^ of) | zf;      // RULE18
			COND_GT:     t = ~((sf ^ of) | zf);   // RULE18
			COND_O:      t = of;                  // RULE14
			COND_NO:     t = ~of;                 // RULE14
			default:     t = 1'b0;
		endcase
		return t;
	endfunction : cond_true

	// ----------------------------------------
	// datapath
	// ----------------------------------------
	always_comb begin
		logic signed [7:0] cnt;
		logic [4:0]        mag;
		logic              left;
		logic [31:0]       val;
		logic [31:0]       res;
		logic [15:0]       sum;
		logic              cy;
		logic              msb;
		int                w;
		s_d            = '0;
		cnt            = '0;
		mag            = '0;
		left           = 1'b0;
		val            = '0;
		res            = '0;
		sum            = '0;
		cy             = c_in;
		msb            = 1'b0;
		w              = word_i ? 16 : 8;
		s_d.pair_high  = pair_high_i;
		if (start_i) begin
			s_d.done = 1'b1;
			// count: signed immediate or signed high byte of the count register
			if (count_imm_i) begin
				cnt = 8'(imm_count_i);
				if (imm_count_i == 5'sd0 || imm_count_i < IMM_COUNT_MIN ||
					imm_count_i > IMM_COUNT_MAX) begin
					s_d.invalid = (op_i == OP_ROT || op_i == OP_SHA || op_i == OP_SHL ||
						op_i == OP_SHA32 || op_i == OP_SHL32); // RULE6
				end
			end else begin
				cnt = signed'(count_reg_i[15:8]); // RULE21
			end
			left = ~cnt[7];
			// compare before negating: -128 has no positive twin in eight bits
			mag  = cnt[7] ? ((cnt < -8'sh1f) ? 5'h1f : 5'(-cnt)) :
				((cnt > 8'sh1f) ? 5'h1f : 5'(cnt));
			val  = word_i ? {16'h0000, dst_i} : {24'h000000, dst_i[7:0]};
			msb  = word_i ? dst_i[15] : dst_i[7];
			case (op_i)
				OP_AND, OP_OR, OP_XOR, OP_NOT, OP_TEST: begin
					case (op_i)
						OP_OR:   res = {16'h0000, src_i | dst_i};
						OP_XOR:  res = {16'h0000, src_i ^ dst_i};
						OP_NOT:  res = {16'h0000, ~dst_i};
						default: res = {16'h0000, src_i & dst_i};
					endcase // RULE19
					if (!word_i) res = {24'h000000, res[7:0]};
					s_d.write_dst = (op_i != OP_TEST); // RULE19
					s_d.flags_we  = 4'b0110; // RULE20
				end
				OP_ROTATE_LEFT_THRU_CARRY: begin
					res = word_i ? {16'h0000, dst_i[14:0], c_in} :
						{24'h000000, dst_i[6:0], c_in}; // RULE1
					cy  = msb; // RULE1
					s_d.write_dst = 1'b1;
					s_d.flags_we  = 4'b0111; // RULE20
				end
				OP_ROTATE_RIGHT_THRU_CARRY: begin
					res = word_i ? {16'h0000, c_in, dst_i[15:1]} :
						{24'h000000, c_in, dst_i[7:1]}; // RULE2
					cy  = dst_i[0]; // RULE2
					s_d.write_dst = 1'b1;
					s_d.flags_we  = 4'b0111; // RULE20
				end
				OP_ROT: begin
					res = val;
					for (int i = 0; i < 16; i++) begin
						if (i < int'(mag) % w) begin
							if (left) begin
								cy  = word_i ? res[15] : res[7];
								res = word_i ? {16'h0000, res[14:0], res[15]} :
									{24'h000000, res[6:0], res[7]}; // RULE3
							end else begin
								cy  = res[0];
								res = word_i ? {16'h0000, res[0], res[15:1]} :
									{24'h000000, res[0], res[7:1]}; // RULE3
							end
						end
					end
					s_d.write_dst = 1'b1;
					s_d.flags_we  = 4'b0111; // RULE20
				end
				OP_SHA, OP_SHL, OP_SHA32, OP_SHL32: begin
					if (op_i == OP_SHA32 || op_i == OP_SHL32) begin
						val = pair_high_i ? high_pair_i : low_pair_i; // RULE7
						w   = 32;
						msb = val[31];
						s_d.write_pair = 1'b1; // RULE7
					end else begin
						s_d.write_dst = 1'b1;
					end
					res = val;
					for (int i = 0; i < 31; i++) begin
						if (i < int'(mag)) begin
							if (left) begin
								cy  = res[w-1];
								res = res << 1; // RULE4 RULE5
							end else begin
								cy  = res[0];
								res = {1'b0, res[31:1]};
								if (op_i == OP_SHA || op_i == OP_SHA32)
									res[w-1] = msb; // RULE4
							end
						end
					end
					if (w == 8) res = {24'h000000, res[7:0]};
					if (w == 16) res = {16'h0000, res[15:0]};
					// overflow when a left arithmetic shift changed the sign
					if (op_i == OP_SHA || op_i == OP_SHA32) begin
						s_d.flags[FLAG_O_POS] = left && (res[w-1] != msb);
						s_d.flags_we = 4'b1111; // RULE20
					end else begin
						s_d.flags_we = 4'b0111; // RULE20
					end
				end
				OP_ADD_BNZ, OP_SUB_BNZ: begin
					sum = (op_i == OP_ADD_BNZ) ? 16'(dst_i + src_i) :
						16'(dst_i - src_i); // RULE8 RULE9
					res = word_i ? {16'h0000, sum} : {24'h000000, sum[7:0]};
					s_d.write_dst = 1'b1; // RULE8 RULE9
					s_d.pc_load   = (res != 32'h00000000); // RULE8 RULE9
					s_d.pc        = target_i;
				end
				OP_JCOND: begin
					s_d.pc_load = cond_true(cond_i, c_in, z_in, s_in, o_in);
					s_d.pc      = s_d.pc_load ? target_i : next_pc_i;
				end
				OP_JMP: begin
					s_d.pc_load = 1'b1; // RULE16
					s_d.pc      = target_i; // RULE16
				end
				OP_CALL_SPECIAL: begin
					s_d.push_ret = 1'b1; // RULE17
					s_d.ret_addr = next_pc_i; // RULE17
					s_d.pc_load  = 1'b1;
					s_d.pc       = SPECIAL_PAGE | special_vector_i; // RULE17
				end
				default: s_d.done = 1'b1;
			endcase
			if (s_d.invalid) begin
				s_d.write_dst  = 1'b0;
				s_d.write_pair = 1'b0;
				s_d.flags_we   = 4'b0000;
				res            = val;
			end
			s_d.result = res;
			s_d.flags[FLAG_C_POS] = cy;
			// res is already zero above the operand width, so test the whole word
			s_d.flags[FLAG_Z_POS] = (res == 32'h00000000);
			s_d.flags[FLAG_S_POS] = res[w-1];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			s_q    <= '0;
			s_q.pc <= PC_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign done_o       = s_q.done;
	assign invalid_o    = s_q.invalid;
	assign result_o     = s_q.result;
	assign write_dst_o  = s_q.write_dst;
	assign write_pair_o = s_q.write_pair;
	assign pair_high_o  = s_q.pair_high;
	assign flags_o      = s_q.flags;
	assign flags_we_o   = s_q.flags_we;
	assign pc_load_o    = s_q.pc_load;
	assign pc_o         = s_q.pc;
	assign push_ret_o   = s_q.push_ret;
	assign ret_addr_o   = s_q.ret_addr;

endmodule : logic_shift_branch_unit

// ===== test/lsb_asserts.sv
// assertion checker for the logic, shift and branch unit
`timescale 1ns/1ps
module lsb_checker
	import lsb_pkg::*;
(
	// watched ports
	input wire logic            clk_i,
	input wire logic            reset_n_i,
	input wire logic            start_i,
	input op_type               op_i,
	input cond_type             cond_i,
	input wire logic            word_i,
	input wire logic            count_imm_i,
	input wire logic signed [4:0] imm_count_i,
	input wire logic [15:0]     src_i,
	input wire logic [15:0]     dst_i,
	input wire logic [3:0]      flags_i,
	input wire logic [PC_W-1:0] next_pc_i,
	input wire logic [PC_W-1:0] target_i,
	input wire logic [PC_W-1:0] special_vector_i,
	input wire logic            done_o,
	input wire logic            invalid_o,
	input wire logic [31:0]     result_o,
	input wire logic            write_dst_o,
	input wire logic [3:0]      flags_we_o,
	input wire logic [3:0]      flags_o,
	input wire logic            pc_load_o,
	input wire logic [PC_W-1:0] pc_o,
	input wire logic            push_ret_o,
	input wire logic [PC_W-1:0] ret_addr_o
);
	// operands one cycle back, beside the registered results
	logic [15:0]     d_q, s_q;
	logic [3:0]      f_q;
	logic [PC_W-1:0] n_q, t_q, v_q;
	always_ff @(posedge clk_i) begin
		d_q <= dst_i;
		s_q <= src_i;
		f_q <= flags_i;
		n_q <= next_pc_i;
		t_q <= target_i;
		v_q <= special_vector_i;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	AST_DONE: assert property (done_o == $past(start_i))
		else $error("done not one cycle after start");
	AST_ROTATE_LEFT_THRU_CARRY: assert property (start_i && op_i == OP_ROTATE_LEFT_THRU_CARRY && word_i |=>
		result_o[15:0] == {d_q[14:0], f_q[FLAG_C_POS]} && flags_o[FLAG_C_POS] == d_q[15])
		else $error("rotate left through carry wrong");
	AST_ROTATE_RIGHT_THRU_CARRY: assert property (start_i && op_i == OP_ROTATE_RIGHT_THRU_CARRY && word_i |=>
		result_o[15:0] == {f_q[FLAG_C_POS], d_q[15:1]} && flags_o[FLAG_C_POS] == d_q[0])
		else $error("rotate right through carry wrong");
	AST_ZERO_COUNT: assert property (start_i && count_imm_i && imm_count_i == 5'sh00 &&
		op_i inside {OP_SHA, OP_SHL, OP_ROT} |=> invalid_o && !write_dst_o && flags_we_o == 4'h0)
		else $error("zero count not refused");
	AST_LOGIC_FLAGS: assert property (start_i && op_i inside {OP_AND, OP_OR, OP_XOR} |=>
		flags_we_o == 4'h6 && write_dst_o) else $error("logic flag enables wrong");
	AST_TEST: assert property (start_i && op_i == OP_TEST && word_i |=>
		!write_dst_o && result_o[15:0] == (d_q & s_q)) else $error("test op wrong");
	AST_EQ: assert property (start_i && op_i == OP_JCOND && cond_i == COND_EQ_Z |=>
		pc_load_o == f_q[FLAG_Z_POS]) else $error("equal branch wrong");
	AST_GT: assert property (start_i && op_i == OP_JCOND && cond_i == COND_GT |=>
		pc_load_o == !((f_q[FLAG_S_POS] ^ f_q[FLAG_O_POS]) | f_q[FLAG_Z_POS]))
		else $error("greater branch wrong");
	AST_JMP: assert property (start_i && op_i == OP_JMP |=> pc_load_o && pc_o == t_q)
		else $error("jump wrong");
	AST_CALL: assert property (start_i && op_i == OP_CALL_SPECIAL |=> push_ret_o &&
		ret_addr_o == n_q && pc_o == (SPECIAL_PAGE | v_q)) else $error("special call wrong");
	AST_ADD: assert property (start_i && op_i == OP_ADD_BNZ && word_i |=>
		result_o[15:0] == 16'(d_q + s_q) && pc_load_o == (result_o[15:0] != 16'h0))
		else $error("add and branch wrong");
endmodule : lsb_checker

bind logic_shift_branch_unit lsb_checker u_lsb_checker (.*);

// ===== test/core_side_model.sv
// flag register and program counter beside the unit
`timescale 1ns/1ps
module core_side_model
	import lsb_pkg::*;
(
	// clock and reset
	input  wire logic            clk_i,
	input  wire logic            reset_n_i,
	// write-back from the unit
	input  wire logic [3:0]      flags_i,
	input  wire logic [3:0]      flags_we_i,
	input  wire logic            pc_load_i,
	input  wire logic [PC_W-1:0] pc_i,
	// held state
	output logic      [3:0]      flag_reg_o,
	output logic      [PC_W-1:0] pc_reg_o
);
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			flag_reg_o <= 4'h0;
			pc_reg_o <= PC_RESET;
		end else begin
			// bits without an enable keep their value
			flag_reg_o <= (flag_reg_o & ~flags_we_i) | (flags_i & flags_we_i);
			if (pc_load_i) begin
				pc_reg_o <= pc_i;
			end
		end
	end
endmodule : core_side_model

// ===== test/tb_logic_shift_branch_unit.sv
// self-checking bench for the logic, shift and branch unit
`timescale 1ns/1ps
module tb_logic_shift_branch_unit
	import lsb_pkg::*;
;
	logic clk_i = 1'b0, reset_n_i = 1'b0, start_i = 1'b0;
	op_type op_i = OP_NOP;
	cond_type cond_i = COND_GEU_C;
	logic word_i = 1'b1, count_imm_i = 1'b1, pair_high_i = 1'b0;
	logic signed [4:0] imm_count_i = 5'sh01;
	logic [15:0] src_i = 16'h0, dst_i = 16'h0, count_reg_i = 16'h0;
	logic [31:0] low_pair_i = 32'h00008001, high_pair_i = 32'h80000010;
	logic [3:0] flags_i = 4'h0;
	logic [PC_W-1:0] next_pc_i = 20'h00104, target_i = 20'h02000, special_vector_i = 20'h00012;
	logic done_o, invalid_o, write_dst_o, write_pair_o, pair_high_o, pc_load_o, push_ret_o;
	logic [31:0] result_o;
	logic [3:0] flags_o, flags_we_o, flag_reg;
	logic [PC_W-1:0] pc_o, ret_addr_o, pc_reg;
	int n_mismatch = 0;
	int cmp_count = 0;

	logic_shift_branch_unit u_logic_shift_branch_unit (.*);
	core_side_model u_core_side_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .flags_i(flags_o),
		.flags_we_i(flags_we_o), .pc_load_i(pc_load_o), .pc_i(pc_o), .flag_reg_o(flag_reg),
		.pc_reg_o(pc_reg));

	always #25 clk_i = ~clk_i;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// one instruction: start for one edge, results looked at in the cycle after
	task automatic go(input op_type op, input logic [15:0] d, input logic [15:0] s,
		input logic [3:0] f);
		@(posedge clk_i);
		op_i <= op;
		dst_i <= d;
		src_i <= s;
		flags_i <= f;
		start_i <= 1'b1;
		@(posedge clk_i);
		start_i <= 1'b0;
		#1;
		chk("done", 32'h1, {31'h0, done_o});
	endtask : go

	task automatic t_logic();
		op_type ops[5] = '{OP_AND, OP_OR, OP_XOR, OP_NOT, OP_TEST};
		logic [15:0] ex[5] = '{16'h3030, 16'hfcfc, 16'hcccc, 16'h0f0f, 16'h3030};
		for (int i = 0; i < 5; i++) begin
			go(ops[i], 16'hf0f0, 16'h3c3c, 4'hf);
			chk("logic", {16'h0, ex[i]}, result_o);
			chk("logic_wr", {31'h0, i < 4}, {31'h0, write_dst_o});
			chk("logic_fwe", 32'h6, {28'h0, flags_we_o});
		end
		word_i <= 1'b0;
		go(OP_AND, 16'h12f0, 16'hff3c, 4'h0);
		chk("byte_and", 32'h30, result_o);
		word_i <= 1'b1;
	endtask : t_logic

	task automatic t_rotc();
		@(posedge clk_i);
		op_i <= OP_ROTATE_LEFT_THRU_CARRY;
		dst_i <= 16'h8001;
		flags_i <= 4'h0;
		start_i <= 1'b1;
		@(posedge clk_i);
		op_i <= OP_ROTATE_RIGHT_THRU_CARRY;
		dst_i <= 16'h0001;
		flags_i <= 4'h1;
		#1;
		chk("rotate_left_thru_carry", 32'h00020001, {result_o[15:0], 15'h0, flags_o[FLAG_C_POS]});
		@(posedge clk_i);
		start_i <= 1'b0;
		#1;
		chk("rotate_right_thru_carry", 32'h80001, {result_o[15:0], 3'h0, flags_o[FLAG_C_POS]});
		@(posedge clk_i);
		#1;
		chk("flag_reg", 32'h5, {28'h0, flag_reg});
	endtask : t_rotc

	task automatic t_shift();
		op_type ops[7] = '{OP_SHA, OP_SHL, OP_SHA, OP_ROT, OP_SHA, OP_SHA32, OP_SHL32};
		logic signed [4:0] cnt[7] = '{5'sh1d, 5'sh1d, 5'sh08, 5'sh01, 5'sh00, 5'sh1f, 5'sh1c};
		logic [15:0] d[7] = '{16'h8000, 16'h8000, 16'h00ff, 16'h0081, 16'h8000, 16'h0, 16'h0};
		logic [31:0] ex[7] = '{32'hf000, 32'h1000, 32'hff00, 32'h3, 32'he000, 32'h4000,
			32'h08000001};
		logic [3:0] we[7] = '{4'hf, 4'h7, 4'hf, 4'h7, 4'hf, 4'hf, 4'h7};
		logic [3:0] fl[7] = '{4'h4, 4'h0, 4'hc, 4'h1, 4'h4, 4'h1, 4'h0};
		count_reg_i <= 16'hfe00;
		for (int i = 0; i < 7; i++) begin
			word_i <= (i != 3);
			count_imm_i <= (i != 4);
			pair_high_i <= (i == 6);
			imm_count_i <= cnt[i];
			go(ops[i], d[i], 16'h0, 4'h0);
			chk("shift", ex[i], result_o);
			chk("shift_fwe", {28'h0, we[i]}, {28'h0, flags_we_o});
			chk("shift_flags", {28'h0, fl[i]}, {28'h0, flags_o});
		end
		chk("pair", 32'h3, {30'h0, write_pair_o, pair_high_o});
		word_i <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			imm_count_i <= (i == 0) ? 5'sh00 : (i == 1) ? 5'sh09 : 5'sh17;
			go(OP_SHL, 16'h1234, 16'h0, 4'h0);
			chk("refuse", 32'h4, {29'h0, invalid_o, write_dst_o, |flags_we_o});
		end
	endtask : t_shift

	task automatic t_branch();
		logic [13:0] t;
		logic c, z, s, o;
		logic [31:0] e;
		for (int k = 0; k < 14; k++) begin
			for (int f = 0; f < 16; f++) begin
				{o, s, z, c} = f[3:0];
				t = {~o, o, ~((s ^ o) | z), (s ^ o) | z, s ^ o, ~(s ^ o), s, ~s,
					~(c & ~z), c & ~z, ~z, z, ~c, c};
				e = {11'h0, t[k], 20'(t[k] ? target_i : next_pc_i)};
				cond_i <= cond_type'(k);
				go(OP_JCOND, 16'h0, 16'h0, f[3:0]);
				chk("cond", e, {11'h0, pc_load_o, pc_o});
			end
		end
		go(OP_JMP, 16'h0, 16'h0, 4'h0);
		@(posedge clk_i);
		#1;
		chk("jump", {12'h0, target_i}, {12'h0, pc_reg});
		go(OP_CALL_SPECIAL, 16'h0, 16'h0, 4'h0);
		chk("call", {11'h0, 1'b1, SPECIAL_PAGE | special_vector_i}, {11'h0, push_ret_o, pc_o});
		chk("ret", {12'h0, next_pc_i}, {12'h0, ret_addr_o});
	endtask : t_branch

	task automatic t_loop();
		op_type ops[4] = '{OP_ADD_BNZ, OP_ADD_BNZ, OP_SUB_BNZ, OP_SUB_BNZ};
		logic [15:0] d[4] = '{16'hfffe, 16'hffff, 16'h0003, 16'h0001};
		logic [15:0] ex[4] = '{16'hffff, 16'h0000, 16'h0002, 16'h0000};
		logic [31:0] e;
		for (int i = 0; i < 4; i++) begin
			go(ops[i], d[i], 16'h0001, 4'h0);
			e = {ex[i], 14'h0, 1'b1, ex[i] != 16'h0};
			chk("loop", e, {result_o[15:0], 14'h0, write_dst_o, pc_load_o});
			if (ex[i] != 16'h0) chk("loop_pc", {12'h0, target_i}, {12'h0, pc_o});
		end
	endtask : t_loop

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	initial begin
		#1000000;
		n_mismatch++;
		close_out();
	end

	initial begin
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_logic();
		t_rotc();
		t_shift();
		t_branch();
		t_loop();
		close_out();
	end
endmodule : tb_logic_shift_branch_unit
